// file: include/flash_spc_defines.svh
// Offsets, field positions, command patterns and timing counts of the self-program controller
`ifndef FLASH_SPC_DEFINES_SVH
`define FLASH_SPC_DEFINES_SVH

// ==========================================================================
// Register map (byte addresses)
`define SPC_OFS_CTRL        32'h0000_0000
`define SPC_OFS_STAT        32'h0000_0004
`define SPC_RESET_CTRL      8'h00

// ==========================================================================
// Control register fields
`define SPC_BIT_ENABLE      0
`define SPC_BIT_ERASE       1
`define SPC_BIT_WRITE       2
`define SPC_BIT_READ        3
`define SPC_BIT_CLEAR       4

// Lower five bit command patterns
`define SPC_CMD_CLEAR       5'h11
`define SPC_CMD_READ        5'h09
`define SPC_CMD_WRITE       5'h05
`define SPC_CMD_ERASE       5'h03
`define SPC_CMD_LOAD        5'h01

// ==========================================================================
// Status register fields
`define SPC_STAT_LOCK_LSB   0
`define SPC_STAT_EEBUSY     2
`define SPC_STAT_OPBUSY     3

// ==========================================================================
// Arming windows, in clock cycles
`define SPC_STORE_WINDOW    3'h4
`define SPC_LOAD_WINDOW     2'h3

// Lock bits, one means unprogrammed
`define SPC_LOCK_BLANK      2'h3
`define SPC_LOCK_MODE3      2'h0

// ==========================================================================
// Programming time
`define SPC_CLK_MHZ         100
`define SPC_OP_MIN_US       3700
`define SPC_OP_MAX_US       4500
`define SPC_OP_MIN_CYCLES   (`SPC_OP_MIN_US * `SPC_CLK_MHZ)
`define SPC_OP_MAX_CYCLES   (`SPC_OP_MAX_US * `SPC_CLK_MHZ)

`endif

// file: include/flash_spc_pkg.sv
// Types of the self-program controller
package flash_spc_pkg;

  typedef enum logic [2:0] {
    ARM_NONE  = 3'h0,
    ARM_LOAD  = 3'h1,
    ARM_ERASE = 3'h3,
    ARM_WRITE = 3'h2,
    ARM_READ  = 3'h6
  } arm_t;

  typedef enum logic [1:0] {
    OP_IDLE = 2'h0,
    OP_RUN  = 2'h1,
    OP_DONE = 2'h3
  } op_state_t;

  typedef enum logic [1:0] {
    KIND_ERASE = 2'h0,
    KIND_WRITE = 2'h1,
    KIND_LOCK  = 2'h2
  } op_kind_t;

  typedef struct packed {
    logic        store;
    logic        load;
    logic [15:0] pointer;
    logic [15:0] dataPair;
  } cpu_req_t;

  typedef struct packed {
    logic        extProgBlock;
    logic        extVerifyBlock;
    logic        fuseLocked;
    logic        debugLinkOn;
    logic        debugReadOk;
  } protect_t;

endpackage

// file: rtl/flash_self_program_control.sv
// Self-program controller: arming register, page buffer, timed flash operations, lock bits
//
// Contract
// - EEPROM write busy refuses flash programming and fuse/lock reads.
// - Armed read plus load within three cycles returns lock bits in bits 1:0.
// - Read arming clears on completion, three cycles without load, or four without store.
// - Without read arming a load returns the ordinary flash byte.
// - Two lowest pointer bits select lock bits or fuse bits during armed read.
// - Clear-buffer command empties the page buffer.
// - Armed page write stores buffer into page from upper pointer bits.
// - Page write arming clears at end or after four idle cycles; core stalls.
// - Armed page erase erases page from upper pointer bits.
// - Page erase arming clears at end or after four idle cycles; core halts.
// - Enable alone lets next store load data pair into buffer word.
// - Enable clears after store or timeout, stays set during erase and write.
// - Only the five listed command patterns have any effect.
// - Erase, write and lock writes last between 3.7 ms and 4.5 ms.
// - A running flash write finishes through a system reset.
// - Lock bits return to unprogrammed only by chip erase.
// - Programmed debug fuse keeps flash readable over the debug link.
// - Lock mode 2 blocks external programming, locks fuses, disables debug link.
// - Lock mode 3 also blocks external verification reads.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "flash_spc_defines.svh"

module flash_self_program_control #(
  parameter int unsigned OP_CYCLES = `SPC_OP_MIN_CYCLES
) (
  // Clock and resets
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    porRst_n,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // CPU store and load instructions
  input  wire flash_spc_pkg::cpu_req_t cpuReq,
  output logic      [7:0]              loadData,
  output logic                         loadValid,
  output logic                         cpuHalt,
  // Flash array
  input  wire logic [7:0]              flashByte,
  output logic                         flashOpActive,
  output flash_spc_pkg::op_kind_t      flashOpKind,
  output logic      [4:0]              flashPage,
  output logic      [255:0]            pageBuf,
  // EEPROM
  input  wire logic                    eepromWriteBusyFlag,
  // Nonvolatile fuses and lock bits
  input  wire logic [7:0]              fuseLowByte,
  input  wire logic [7:0]              fuseHighByte,
  input  wire logic                    debugLinkEnableFuse,
  input  wire logic [1:0]              lockStored,
  input  wire logic                    chipErase,
  input  wire logic                    lockProgReq,
  input  wire logic [1:0]              lockProgData,
  output logic      [1:0]              lockBits,
  output flash_spc_pkg::protect_t      protect
);
  import flash_spc_pkg::*;

  // ========================================================================
  // State of the system-reset domain
  typedef struct packed {
    arm_t             arm;
    logic             hold;
    logic [2:0]       storeWin;
    logic [1:0]       loadWin;
    logic [15:0][15:0] bufWords;
    logic [15:0]      bufFull;
    logic             opReq;
    op_kind_t         opReqKind;
    logic [4:0]       opReqPage;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [7:0]       loadData;
    logic             loadValid;
  } ctl_state_t;

  // State of the power-on domain, survives system reset
  typedef struct packed {
    op_state_t        state;
    op_kind_t         kind;
    logic [4:0]       page;
    logic [18:0]      cnt;
    logic [1:0]       pendLock;
    logic             loaded;
    logic [1:0]       lockBits;
    logic             busy;
    protect_t         protect;
  } op_state_reg_t;

  ctl_state_t    ctl_r;
  ctl_state_t    ctl_nxt;
  op_state_reg_t op_r;
  op_state_reg_t op_nxt;

  logic [7:0]    ctrlView;
  logic          opDone;
  logic [3:0]    wordIdx;
  logic          apbWrite;

  assign opDone   = (op_r.state == OP_DONE);
  assign wordIdx  = cpuReq.pointer[4:1];
  assign apbWrite = psel && penable && pwrite && ctl_r.pready;

  // Read view of the control register, upper bits zero
  always_comb
  begin
    ctrlView                 = 8'h00;
    ctrlView[`SPC_BIT_ENABLE] = (ctl_r.arm != ARM_NONE);
    ctrlView[`SPC_BIT_ERASE]  = (ctl_r.arm == ARM_ERASE);
    ctrlView[`SPC_BIT_WRITE]  = (ctl_r.arm == ARM_WRITE);
    ctrlView[`SPC_BIT_READ]   = (ctl_r.arm == ARM_READ);
  end

  // ========================================================================
  // Arming, buffer, CPU instructions and register bus
  always_comb
  begin
    ctl_nxt           = ctl_r;
    ctl_nxt.pready    = 1'b0;
    ctl_nxt.pslverr   = 1'b0;
    ctl_nxt.loadValid = 1'b0;
    ctl_nxt.opReq     = 1'b0;

    // Window countdown and expiry
    if (ctl_r.storeWin != 3'h0)
    begin
      ctl_nxt.storeWin = ctl_r.storeWin - 3'h1;
    end
    if (ctl_r.loadWin != 2'h0)
    begin
      ctl_nxt.loadWin = ctl_r.loadWin - 2'h1;
    end
    if (!ctl_r.hold && ctl_r.storeWin == 3'h1)
    begin
      ctl_nxt.arm = ARM_NONE;
    end
    if (ctl_r.arm == ARM_READ && ctl_r.loadWin == 2'h1)
    begin
      ctl_nxt.arm = ARM_NONE;
    end

    // End of a held erase or write
    if (ctl_r.hold && opDone)
    begin
      ctl_nxt.hold = 1'b0;
      ctl_nxt.arm  = ARM_NONE;
      if (ctl_r.arm == ARM_WRITE)
      begin
        ctl_nxt.bufFull  = 16'h0000;
        ctl_nxt.bufWords = '0;
      end
    end

    // Store instruction
    if (cpuReq.store && ctl_r.storeWin != 3'h0 && !ctl_r.hold && !op_r.busy
        && !eepromWriteBusyFlag)
    begin
      ctl_nxt.storeWin = 3'h0;
      ctl_nxt.loadWin  = 2'h0;
      case (ctl_r.arm)
        ARM_LOAD:
        begin
          if (!ctl_r.bufFull[wordIdx])
          begin
            ctl_nxt.bufWords[wordIdx] = cpuReq.dataPair;
            ctl_nxt.bufFull[wordIdx]  = 1'b1;
          end
          ctl_nxt.arm = ARM_NONE;
        end
        ARM_ERASE:
        begin
          ctl_nxt.opReq     = 1'b1;
          ctl_nxt.opReqKind = KIND_ERASE;
          ctl_nxt.opReqPage = cpuReq.pointer[9:5];
          ctl_nxt.hold      = 1'b1;
        end
        ARM_WRITE:
        begin
          ctl_nxt.opReq     = 1'b1;
          ctl_nxt.opReqKind = KIND_WRITE;
          ctl_nxt.opReqPage = cpuReq.pointer[9:5];
          ctl_nxt.hold      = 1'b1;
        end
        default:
        begin
          ctl_nxt.arm = ARM_NONE;
        end
      endcase
    end

    // Load instruction
    if (cpuReq.load)
    begin
      ctl_nxt.loadValid = 1'b1;
      if (ctl_r.arm == ARM_READ && ctl_r.loadWin != 2'h0 && !eepromWriteBusyFlag)
      begin
        if (cpuReq.pointer[1])
        begin
          ctl_nxt.loadData = fuseHighByte;
        end
        else if (cpuReq.pointer[0])
        begin
          ctl_nxt.loadData = {6'h00, op_r.lockBits};
        end
        else
        begin
          ctl_nxt.loadData = fuseLowByte;
        end
        ctl_nxt.arm      = ARM_NONE;
        ctl_nxt.storeWin = 3'h0;
        ctl_nxt.loadWin  = 2'h0;
      end
      else
      begin
        ctl_nxt.loadData = flashByte;
      end
    end

    // Register bus: answer in the first access cycle
    if (psel && !penable && !ctl_r.pready)
    begin
      ctl_nxt.pready = 1'b1;
      ctl_nxt.prdata = 32'h0000_0000;
      if (paddr == `SPC_OFS_CTRL)
      begin
        ctl_nxt.prdata[7:0] = ctrlView;
      end
      else if (paddr == `SPC_OFS_STAT)
      begin
        ctl_nxt.prdata[`SPC_STAT_LOCK_LSB +: 2] = op_r.lockBits;
        ctl_nxt.prdata[`SPC_STAT_EEBUSY]        = eepromWriteBusyFlag;
        ctl_nxt.prdata[`SPC_STAT_OPBUSY]        = op_r.busy;
      end
      else
      begin
        ctl_nxt.pslverr = 1'b1;
      end
    end

    // Control write takes effect at the access edge
    if (apbWrite && paddr == `SPC_OFS_CTRL && !eepromWriteBusyFlag
        && !ctl_r.hold && !op_r.busy)
    begin
      case (pwdata[4:0])
        `SPC_CMD_CLEAR:
        begin
          ctl_nxt.bufFull  = 16'h0000;
          ctl_nxt.bufWords = '0;
          ctl_nxt.arm      = ARM_NONE;
          ctl_nxt.storeWin = 3'h0;
          ctl_nxt.loadWin  = 2'h0;
        end
        `SPC_CMD_READ:
        begin
          ctl_nxt.arm      = ARM_READ;
          ctl_nxt.storeWin = `SPC_STORE_WINDOW;
          ctl_nxt.loadWin  = `SPC_LOAD_WINDOW;
        end
        `SPC_CMD_WRITE:
        begin
          ctl_nxt.arm      = ARM_WRITE;
          ctl_nxt.storeWin = `SPC_STORE_WINDOW;
          ctl_nxt.loadWin  = 2'h0;
        end
        `SPC_CMD_ERASE:
        begin
          ctl_nxt.arm      = ARM_ERASE;
          ctl_nxt.storeWin = `SPC_STORE_WINDOW;
          ctl_nxt.loadWin  = 2'h0;
        end
        `SPC_CMD_LOAD:
        begin
          ctl_nxt.arm      = ARM_LOAD;
          ctl_nxt.storeWin = `SPC_STORE_WINDOW;
          ctl_nxt.loadWin  = 2'h0;
        end
        default:
        begin
          // Other patterns leave arming and window countdown alone
        end
      endcase
    end

    // EEPROM write in the middle of page loading loses the buffer
    if (eepromWriteBusyFlag && !ctl_r.hold)
    begin
      ctl_nxt.bufFull  = 16'h0000;
      ctl_nxt.bufWords = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_r <= '0;
    end
    else
    begin
      ctl_r <= ctl_nxt;
    end
  end

  // ========================================================================
  // Timed operations and lock bits, reset only at power-on
  always_comb
  begin
    op_nxt = op_r;
    if (!op_r.loaded)
    begin
      op_nxt.loaded   = 1'b1;
      op_nxt.lockBits = lockStored;
    end
    case (op_r.state)
      OP_IDLE:
      begin
        if (ctl_r.opReq)
        begin
          op_nxt.state = OP_RUN;
          op_nxt.kind  = ctl_r.opReqKind;
          op_nxt.page  = ctl_r.opReqPage;
          op_nxt.cnt   = 19'(OP_CYCLES - 1);
        end
        else if (lockProgReq && !ctl_r.hold)
        begin
          op_nxt.state    = OP_RUN;
          op_nxt.kind     = KIND_LOCK;
          op_nxt.pendLock = lockProgData;
          op_nxt.cnt      = 19'(OP_CYCLES - 1);
        end
        else if (chipErase)
        begin
          op_nxt.lockBits = `SPC_LOCK_BLANK;
        end
      end
      OP_RUN:
      begin
        if (op_r.cnt == 19'h0)
        begin
          op_nxt.state = OP_DONE;
          if (op_r.kind == KIND_LOCK)
          begin
            op_nxt.lockBits = op_r.lockBits & op_r.pendLock;
          end
        end
        else
        begin
          op_nxt.cnt = op_r.cnt - 19'h1;
        end
      end
      default:
      begin
        op_nxt.state = OP_IDLE;
      end
    endcase
    op_nxt.busy                   = (op_nxt.state != OP_IDLE);
    op_nxt.protect.extProgBlock   = (op_nxt.lockBits != `SPC_LOCK_BLANK);
    op_nxt.protect.fuseLocked     = (op_nxt.lockBits != `SPC_LOCK_BLANK);
    op_nxt.protect.extVerifyBlock = (op_nxt.lockBits == `SPC_LOCK_MODE3);
    op_nxt.protect.debugLinkOn    = !debugLinkEnableFuse
                                    && (op_nxt.lockBits == `SPC_LOCK_BLANK);
    op_nxt.protect.debugReadOk    = !debugLinkEnableFuse;
  end

  // System reset does not reach here, so a running write completes
  always_ff @(posedge clk or negedge porRst_n)
  begin
    if (!porRst_n)
    begin
      op_r <= '0;
    end
    else
    begin
      op_r <= op_nxt;
    end
  end

  // ========================================================================
  // Outputs
  assign prdata        = ctl_r.prdata;
  assign pready        = ctl_r.pready;
  assign pslverr       = ctl_r.pslverr;
  assign loadData      = ctl_r.loadData;
  assign loadValid     = ctl_r.loadValid;
  assign pageBuf       = ctl_r.bufWords;
  assign cpuHalt       = op_r.busy;
  assign flashOpActive = op_r.busy;
  assign flashOpKind   = op_r.kind;
  assign flashPage     = op_r.page;
  assign lockBits      = op_r.lockBits;
  assign protect       = op_r.protect;

endmodule // flash_self_program_control

// file: testbench/flash_spc_props.sv
// Port checks of the self-program controller
`timescale 1ns/10ps
module flash_spc_props #(
  parameter int unsigned OP_CYCLES = 20
) (
  // Clock and resets
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    porRst_n,
  // APB
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             paddr,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // CPU, fuses and lock
  input wire flash_spc_pkg::cpu_req_t cpuReq,
  input wire logic                    loadValid,
  input wire logic                    cpuHalt,
  input wire logic                    debugLinkEnableFuse,
  input wire logic                    chipErase,
  input wire logic [1:0]              lockBits,
  input wire flash_spc_pkg::protect_t protect
);
  import flash_spc_pkg::*;
  int unsigned haltLen;
  logic [1:0]  porAge;

  // Halt length and settling age after power-on release
  always_ff @(posedge clk or negedge porRst_n)
    if (!porRst_n)
    begin
      haltLen <= 0;
      porAge  <= 2'h0;
    end
    else
    begin
      haltLen <= cpuHalt ? haltLen + 1 : 0;
      porAge  <= (porAge == 2'h3) ? porAge : porAge + 2'h1;
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !porRst_n);

  sequence apbSetup;
    psel && !penable;
  endsequence
  sequence lockSettled;
    porAge == 2'h3 && $stable(lockBits) && $stable(debugLinkEnableFuse);
  endsequence

  a_ready_pulse: assert property (apbSetup |=> pready ##1 !pready)
    else $error("pready not a single pulse after setup");
  a_unmapped_err: assert property (apbSetup ##0 (paddr != 32'h0 && paddr != 32'h4)
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not flagged");
  a_reserved_zero: assert property (apbSetup ##0 (paddr == 32'h0 && !pwrite)
    |=> !pslverr && prdata[31:4] == 28'h0) else $error("control upper bits not zero");
  a_load_answer: assert property (cpuReq.load |=> loadValid ##1 !loadValid)
    else $error("load answer missing");
  a_halt_length: assert property ($fell(cpuHalt) |-> haltLen == OP_CYCLES + 1)
    else $error("operation length wrong");
  a_fuse_lock: assert property (lockSettled ##1 lockSettled |->
    protect.fuseLocked == (lockBits != 2'h3) && protect.extProgBlock == (lockBits != 2'h3))
    else $error("fuse lock or program block wrong");
  a_verify_block: assert property (lockSettled ##1 lockSettled |->
    protect.extVerifyBlock == (lockBits == 2'h0)) else $error("verify block wrong");
  a_debug_gate: assert property (lockSettled ##1 lockSettled |->
    protect.debugLinkOn == (!debugLinkEnableFuse && lockBits == 2'h3)
    && protect.debugReadOk == !debugLinkEnableFuse) else $error("debug link gating wrong");
  a_lock_rise: assert property (porAge == 2'h3 && (lockBits & ~$past(lockBits)) != 2'h0
    |-> $past(chipErase) || $past(chipErase, 2)) else $error("lock bit raised without erase");
endmodule // flash_spc_props

bind flash_self_program_control flash_spc_props #(.OP_CYCLES(OP_CYCLES)) u_props (
  .clk, .rst_n, .porRst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .cpuReq, .loadValid, .cpuHalt, .debugLinkEnableFuse, .chipErase,
  .lockBits, .protect
);

// file: testbench/cpu_model.sv
// CPU core model issuing store and load instructions, with a flash array pattern
`timescale 1ns/10ps
module cpu_model (
  // Clock
  input  wire logic               clk,
  // Instructions and flash array
  output flash_spc_pkg::cpu_req_t cpuReq,
  output logic [7:0]              flashByte
);
  import flash_spc_pkg::*;
  assign flashByte = cpuReq.pointer[7:0] ^ 8'hA5;
  initial cpuReq = '0;

  // One-cycle instruction; released data pair is inverted
  task automatic issue(input logic st, input logic [15:0] ptr, input logic [15:0] dat);
    cpuReq <= '{store: st, load: !st, pointer: ptr, dataPair: dat};
    @(posedge clk);
    cpuReq.store    <= 1'b0;
    cpuReq.load     <= 1'b0;
    cpuReq.dataPair <= ~dat;
  endtask
endmodule // cpu_model

// file: testbench/flash_self_program_control_tb.sv
// Self-checking bench of the self-program controller
`timescale 1ns/10ps
module flash_self_program_control_tb;
  import flash_spc_pkg::*;
  localparam int unsigned OPC = 20;
  logic clk, rst_n, porRst_n, psel, penable, pwrite, pready, pslverr, err;
  logic loadValid, cpuHalt, flashOpActive, eepromWriteBusyFlag;
  logic debugLinkEnableFuse, chipErase, lockProgReq;
  logic [31:0]  paddr, pwdata, prdata, rdv;
  logic [7:0]   loadData, flashByte;
  logic [4:0]   flashPage;
  logic [1:0]   lockProgData, lockBits;
  logic [255:0] pageBuf;
  cpu_req_t     cpuReq;
  op_kind_t     flashOpKind;
  protect_t     protect;
  int           n_mismatch = 0;
  int           tests_run = 0;
  logic [15:0]  ptrs [3] = '{16'h1, 16'h0, 16'h3};
  logic [7:0]   vals [3] = '{8'h03, 8'h6A, 8'hD5};
  logic [7:0]   bad [5] = '{8'h07, 8'h0F, 8'h13, 8'h02, 8'h1F};
  logic [1:0]   lkd [3] = '{2'h2, 2'h3, 2'h1};
  logic [1:0]   lke [3] = '{2'h2, 2'h2, 2'h0};
  logic [4:0]   pre [3] = '{5'h15, 5'h15, 5'h1D};

  flash_self_program_control #(.OP_CYCLES(OPC)) u_dut (
    .clk, .rst_n, .porRst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cpuReq, .loadData, .loadValid, .cpuHalt, .flashByte,
    .flashOpActive, .flashOpKind, .flashPage, .pageBuf, .eepromWriteBusyFlag,
    .fuseLowByte(8'h6A), .fuseHighByte(8'hD5), .debugLinkEnableFuse,
    .lockStored(2'h3), .chipErase, .lockProgReq, .lockProgData, .lockBits, .protect
  );
  cpu_model u_cpu (.clk, .cpuReq, .flashByte);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================
  // Tasks
  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic giveUp(input string nm);
    chk(nm, 1, 0);
    final_report();
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      giveUp("pready");
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [31:0] d);
    apb(1'b1, 32'h0, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("reg", e, rdv);
  endtask

  task automatic ld(input logic [15:0] p, input logic [7:0] e);
    u_cpu.issue(1'b0, p, 16'h0);
    @(posedge clk);
    chk("loadValid", 1, loadValid);
    chk("loadData", e, loadData);
  endtask

  task automatic st(input logic [15:0] p, input logic [15:0] d);
    u_cpu.issue(1'b1, p, d);
    @(posedge clk);
  endtask

  task automatic waitHalt(input logic v);
    int n;
    n = 0;
    while (cpuHalt !== v && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (cpuHalt !== v)
      giveUp("halt");
  endtask

  // ==========================================
  // Sequence
  initial
  begin
    rst_n = 1'b0;
    porRst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    eepromWriteBusyFlag = 1'b0;
    debugLinkEnableFuse = 1'b1;
    chipErase = 1'b0;
    lockProgReq = 1'b0;
    lockProgData = 2'h3;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    porRst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h3);
    apb(1'b0, 32'h8, 32'h0);
    chk("slverr", 1, err);
    for (int i = 0; i < 3; i++)
    begin
      wr(32'h9);
      ld(ptrs[i], vals[i]);
      rd(32'h0, 32'h0);
    end
    wr(32'h9);
    repeat (2) @(posedge clk);
    ld(16'h1, 8'hA4);
    foreach (bad[i])
    begin
      wr({24'h0, bad[i]});
      rd(32'h0, 32'h0);
    end
    eepromWriteBusyFlag <= 1'b1;
    wr(32'h9);
    ld(16'h1, 8'hA4);
    wr(32'h3);
    st(16'h00A0, 16'h0);
    repeat (2) @(posedge clk);
    chk("halt", 0, cpuHalt);
    rd(32'h4, 32'h7);
    eepromWriteBusyFlag <= 1'b0;
    wr(32'h1);
    st(16'h0006, 16'hBEEF);
    chk("word3", 16'hBEEF, pageBuf[63:48]);
    rd(32'h0, 32'h0);
    wr(32'h1);
    st(16'h0007, 16'h1234);
    chk("word3", 16'hBEEF, pageBuf[63:48]);
    wr(32'h11);
    chk("buf", 0, pageBuf);
    wr(32'h3);
    wr(32'h3);
    @(posedge clk);
    u_cpu.issue(1'b1, 16'h00A0, 16'h0);
    waitHalt(1'b1);
    chk("kind", KIND_ERASE, flashOpKind);
    chk("page", 5'h5, flashPage);
    chk("active", 1, flashOpActive);
    rd(32'h0, 32'h3);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("halt", 1, cpuHalt);
    waitHalt(1'b0);
    rd(32'h0, 32'h0);
    wr(32'h3);
    repeat (3) @(posedge clk);
    st(16'h00A0, 16'h0);
    repeat (2) @(posedge clk);
    chk("halt", 0, cpuHalt);
    rd(32'h0, 32'h0);
    wr(32'h1);
    st(16'h0001, 16'hC0DE);
    chk("word0", 16'hC0DE, pageBuf[15:0]);
    wr(32'h5);
    u_cpu.issue(1'b1, 16'h0040, 16'h0);
    waitHalt(1'b1);
    chk("kind", KIND_WRITE, flashOpKind);
    chk("page", 5'h2, flashPage);
    rd(32'h0, 32'h5);
    waitHalt(1'b0);
    @(posedge clk);
    chk("buf", 0, pageBuf);
    chk("prot", 5'h00, protect);
    debugLinkEnableFuse <= 1'b0;
    foreach (lkd[i])
    begin
      lockProgReq <= 1'b1;
      lockProgData <= lkd[i];
      @(posedge clk);
      lockProgReq <= 1'b0;
      waitHalt(1'b1);
      chk("kind", KIND_LOCK, flashOpKind);
      waitHalt(1'b0);
      repeat (2) @(posedge clk);
      chk("lock", lke[i], lockBits);
      chk("prot", pre[i], protect);
      wr(32'h9);
      ld(16'h1, {6'h00, lke[i]});
    end
    chipErase <= 1'b1;
    @(posedge clk);
    chipErase <= 1'b0;
    repeat (3) @(posedge clk);
    chk("lock", 2'h3, lockBits);
    chk("prot", 5'h03, protect);
    final_report();
  end
endmodule // flash_self_program_control_tb
